// ### rtl/sgirc_pkg.sv
// package of types and constants for the status, pin and start-up block
package sgirc_pkg;

  localparam int          NUM_PINS      = 4;
  localparam int          NUM_FLAGS     = 4;
  localparam int          NUM_OUTS      = 4;
  // flag positions in the interrupt status vector
  localparam int          FLG_LOL       = 0;
  localparam int          FLG_HOLD      = 1;
  localparam int          FLG_LOS0      = 2;
  localparam int          FLG_LOS1      = 3;
  // pin positions of fixed functions
  localparam int          PIN_HOLD      = 0;
  localparam int          PIN_LOS1      = 1;
  localparam int          PIN_LOS0      = 2;
  localparam int          PIN_LOL       = 3;
  localparam int          PIN_REFSEL    = 2;
  // reset values
  localparam logic [3:0]  RST_DIR_OUT   = 4'h0;
  localparam logic [3:0]  RST_GP_MODE   = 4'h0;
  localparam logic [3:0]  RST_GP_OUT    = 4'h0;
  localparam logic [3:0]  RST_FLAGS     = 4'h0;
  localparam logic [3:0]  RST_ENABLES   = 4'h0;
  localparam logic [3:0]  RST_OE        = 4'h0;
  localparam logic [3:0]  RST_OE_N      = 4'hF;
  // timing, figure as printed and derived cycle count
  localparam int          CLK_MHZ       = 50;
  localparam int          POR_TIME_US   = 10;
  localparam int          POR_CYCLES    = POR_TIME_US * CLK_MHZ;

  typedef enum logic [2:0] {
    SGIRC_ST_RESET,
    SGIRC_ST_POR,
    SGIRC_ST_OTP,
    SGIRC_ST_EEP,
    SGIRC_ST_REST,
    SGIRC_ST_LOCK,
    SGIRC_ST_RUN
  } sgirc_state_e;

  // pin configuration from the register side
  typedef struct packed {
    logic [3:0] dir_out;
    logic [3:0] gp_mode;
    logic [3:0] gp_out;
  } sgirc_pin_cfg_s;

  // pll and reference status inputs
  typedef struct packed {
    logic       pll_locked;
    logic       sync_done;
    logic       holdover;
    logic [1:0] ref_failed;
  } sgirc_pll_sts_s;

endpackage : sgirc_pkg

// ### rtl/sgirc_oe_map_mem.sv
// four-entry output-enable map store with registered read
`timescale 1ns/1ps
`default_nettype none
module sgirc_oe_map_mem #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 4
) (
  input  wire logic                     i_mclk,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_we,
  input  wire logic [$clog2(DEPTH)-1:0] i_waddr,
  input  wire logic [WIDTH-1:0]         i_wdata,
  input  wire logic [$clog2(DEPTH)-1:0] i_raddr,
  output logic      [WIDTH-1:0]         o_rdata
);

  logic [DEPTH-1:0][WIDTH-1:0] mem_reg;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mem_reg <= '0;
      o_rdata <= '0;
    end else begin
      if (i_we) begin
        mem_reg[i_waddr] <= i_wdata;
      end
      o_rdata <= mem_reg[i_raddr];
    end
  end

endmodule : sgirc_oe_map_mem
`default_nettype wire

// ### rtl/sgirc_por_timer.sv
// power-up reset timer, counts out after the reset input is released
`timescale 1ns/1ps
`default_nettype none
module sgirc_por_timer #(
  parameter int CYCLES = 500
) (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  output logic      o_por_active
);

  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_reg;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
    end else if (cnt_reg != CW'(CYCLES)) begin
      cnt_reg <= cnt_reg + CW'(1);
    end
  end

  assign o_por_active = (cnt_reg != CW'(CYCLES));

endmodule : sgirc_por_timer
`default_nettype wire

// ### rtl/sgirc_top.sv
// status pins, interrupt flags and start-up sequencer of the clock translator
// Function
// - four pins, each set as input or output by configuration
// - each pin chooses general-purpose control or its fixed function
// - before configuration load, all pins are inputs: pins1..0 act as output-enable selects, pin2 as reference select
// - fixed inputs: pin2 reference select, pins1..0 output-enable map select
// - fixed outputs: pin3 unlock, pin2 ref0 loss, pin1 ref1 loss, pin0 holdover
// - unlock status high while pll not locked
// - each loss-of-signal status high while its reference has failed
// - holdover status high while pll in holdover
// - general input bit continuously copies pin level on general-mode inputs only, reads 0 on other pins
// - general output pin drives last written output bit
// - unlock deasserts on lock, or on lock plus sync done, selectable
// - separate sticky flags for unlock, holdover, and each reference loss
// - flag clears only on write-one after alarm gone, or reset
// - per-flag enables, all disabled after reset
// - device interrupt asserted when any enabled flag is set
// - two-bit map select picks one of four stored output-enable maps
// - reset state while either external reset is active; the power-up reset timer runs after release
// - in reset registers default and state machines held
// - in reset: serial ignored, pins inputs, outputs off, flags cleared
// - leave reset after both resets released, then self-configure
// - load initial block, then external memory, internal, or both
// - serial access and pll lock attempt only after full configuration
// - no serial answer during external-memory boot
`timescale 1ns/1ps
`default_nettype none
module sgirc_top #(
  parameter int POR_CYCLES_P = sgirc_pkg::POR_CYCLES
) (
  input  wire logic                     i_mclk,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_master_reset_in_n,
  input  wire logic [3:0]               i_gpio,
  output logic      [3:0]               o_gpio,
  output logic      [3:0]               o_gpio_oe_n,
  input  wire sgirc_pkg::sgirc_pin_cfg_s i_pin_cfg,
  input  wire logic                     i_cfg_we,
  input  wire logic                     i_unlock_mode_sync,
  input  wire sgirc_pkg::sgirc_pll_sts_s i_pll_sts,
  input  wire logic [3:0]               i_flag_clr,
  input  wire logic [3:0]               i_irq_enable,
  input  wire logic                     i_irq_enable_we,
  input  wire logic                     i_oe_map_we,
  input  wire logic [1:0]               i_oe_map_idx,
  input  wire logic [3:0]               i_oe_map_data,
  input  wire logic                     i_otp_done,
  input  wire logic                     i_boot_eep,
  input  wire logic                     i_boot_otp_rest,
  input  wire logic                     i_eep_done,
  input  wire logic                     i_rest_done,
  output logic                          o_otp_load,
  output logic                          o_eep_load,
  output logic                          o_rest_load,
  output logic                          o_serial_accept,
  output logic                          o_pll_lock_try,
  output logic                          o_outputs_sync,
  output logic      [3:0]               o_general_input_bit,
  output logic                          o_manual_ref_select,
  output logic      [1:0]               o_oe_map_select,
  output logic      [3:0]               o_clk_out_en,
  output logic      [3:0]               o_flags,
  output logic                          o_dev_irq,
  output logic                          o_irq_out_n,
  output logic                          o_pll_unlocked_flag,
  output logic      [1:0]               o_ref_signal_lost_flag,
  output logic                          o_holdover_flag
);

  typedef struct packed {
    sgirc_pkg::sgirc_state_e   st;
    sgirc_pkg::sgirc_pin_cfg_s cfg;
    logic                      cfg_loaded;
    logic [3:0]                flags;
    logic [3:0]                en;
    logic [3:0]                general_input_bit;
    logic [3:0]                gout;
    logic [3:0]                oe_n;
    logic                      irq;
    logic                      unlocked;
  } sgirc_state_s;

  sgirc_state_s s_reg;
  sgirc_state_s s_next;
  logic         rst_comb_n;
  logic         por_active;
  logic [3:0]   map_rdata;
  logic [3:0]   alarm;
  logic         running;
  logic         unlock_now;
  logic [3:0]   fixed_vec;

  // either reset source forces the whole block into reset
  assign rst_comb_n = i_rst_n & i_master_reset_in_n;

  sgirc_por_timer #(
    .CYCLES       (POR_CYCLES_P)
  ) u_por (
    .i_mclk       (i_mclk),
    .i_rst_n      (rst_comb_n),
    .o_por_active (por_active)
  );

  sgirc_oe_map_mem #(
    .WIDTH   (sgirc_pkg::NUM_OUTS),
    .DEPTH   (4)
  ) u_map (
    .i_mclk  (i_mclk),
    .i_rst_n (rst_comb_n),
    .i_we    (i_oe_map_we & running),
    .i_waddr (i_oe_map_idx),
    .i_wdata (i_oe_map_data),
    .i_raddr (o_oe_map_select),
    .o_rdata (map_rdata)
  );

  assign running = (s_reg.st == sgirc_pkg::SGIRC_ST_LOCK) || (s_reg.st == sgirc_pkg::SGIRC_ST_RUN);

  // unlock drops on lock alone or waits for sync completion
  assign unlock_now = !i_pll_sts.pll_locked
                      || (i_unlock_mode_sync && !i_pll_sts.sync_done);

  always_comb begin
    alarm                       = '0;
    alarm[sgirc_pkg::FLG_LOL]   = s_reg.unlocked;
    alarm[sgirc_pkg::FLG_HOLD]  = i_pll_sts.holdover;
    alarm[sgirc_pkg::FLG_LOS0]  = i_pll_sts.ref_failed[0];
    alarm[sgirc_pkg::FLG_LOS1]  = i_pll_sts.ref_failed[1];
  end

  always_comb begin
    s_next = s_reg;
    s_next.unlocked = unlock_now;
    case (s_reg.st)
      sgirc_pkg::SGIRC_ST_RESET: s_next.st = sgirc_pkg::SGIRC_ST_POR;
      sgirc_pkg::SGIRC_ST_POR: begin
        if (!por_active) begin
          s_next.st = sgirc_pkg::SGIRC_ST_OTP;
        end
      end
      sgirc_pkg::SGIRC_ST_OTP: begin
        if (i_otp_done) begin
          s_next.cfg_loaded = 1'b1;
          if (i_boot_eep) begin
            s_next.st = sgirc_pkg::SGIRC_ST_EEP;
          end else begin
            s_next.st = sgirc_pkg::SGIRC_ST_REST;
          end
        end
      end
      sgirc_pkg::SGIRC_ST_EEP: begin
        if (i_eep_done) begin
          s_next.st = i_boot_otp_rest ? sgirc_pkg::SGIRC_ST_REST
                                      : sgirc_pkg::SGIRC_ST_LOCK;
        end
      end
      sgirc_pkg::SGIRC_ST_REST: begin
        if (i_rest_done) begin
          s_next.st = sgirc_pkg::SGIRC_ST_LOCK;
        end
      end
      sgirc_pkg::SGIRC_ST_LOCK: begin
        if (i_pll_sts.pll_locked) begin
          s_next.st = sgirc_pkg::SGIRC_ST_RUN;
        end
      end
      sgirc_pkg::SGIRC_ST_RUN: s_next.st = sgirc_pkg::SGIRC_ST_RUN;
      default: s_next.st = sgirc_pkg::SGIRC_ST_RESET;
    endcase
    // configuration writes land only once serial access is open
    if (i_cfg_we && running) begin
      s_next.cfg = i_pin_cfg;
    end
    if (i_irq_enable_we && running) begin
      s_next.en = i_irq_enable;
    end
    for (int i = 0; i < sgirc_pkg::NUM_FLAGS; i++) begin
      // set wins; a clear is honoured only once the alarm has gone
      if (alarm[i]) begin
        s_next.flags[i] = 1'b1;
      end else if (i_flag_clr[i] && running) begin
        s_next.flags[i] = 1'b0;
      end
    end
    s_next.irq = |(s_next.flags & s_next.en);
    s_next.general_input_bit = i_gpio;
    // pin drive: until configuration is loaded every pin stays an input
    for (int i = 0; i < sgirc_pkg::NUM_PINS; i++) begin
      s_next.gout[i] = s_next.cfg.gp_mode[i] ? s_next.cfg.gp_out[i] : fixed_vec[i];
      s_next.oe_n[i] = !(s_next.cfg_loaded && s_next.cfg.dir_out[i]);
    end
  end

  // fixed output function per pin; unlock taken from its next value so pin and flag agree
  for (genvar g = 0; g < sgirc_pkg::NUM_PINS; g++) begin : g_pin
    logic fixed_val;
    always_comb begin
      case (g)
        sgirc_pkg::PIN_LOL:  fixed_val = unlock_now;
        sgirc_pkg::PIN_LOS0: fixed_val = i_pll_sts.ref_failed[0];
        sgirc_pkg::PIN_LOS1: fixed_val = i_pll_sts.ref_failed[1];
        default:             fixed_val = i_pll_sts.holdover;
      endcase
    end
    assign fixed_vec[g] = fixed_val;
  end

  always_ff @(posedge i_mclk or negedge rst_comb_n) begin
    if (!rst_comb_n) begin
      s_reg.st         <= sgirc_pkg::SGIRC_ST_RESET;
      s_reg.cfg        <= '{dir_out: sgirc_pkg::RST_DIR_OUT, gp_mode: sgirc_pkg::RST_GP_MODE,
                            gp_out: sgirc_pkg::RST_GP_OUT};
      s_reg.cfg_loaded <= 1'b0;
      s_reg.flags      <= sgirc_pkg::RST_FLAGS;
      s_reg.en         <= sgirc_pkg::RST_ENABLES;
      s_reg.general_input_bit        <= '0;
      s_reg.gout       <= '0;
      s_reg.oe_n       <= sgirc_pkg::RST_OE_N;
      s_reg.irq        <= 1'b0;
      s_reg.unlocked   <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_gpio      = s_reg.gout;
  assign o_gpio_oe_n = s_reg.oe_n;
  // general input copies live pin level for general-mode inputs
  assign o_general_input_bit = s_reg.general_input_bit & s_reg.cfg.gp_mode & ~s_reg.cfg.dir_out;
  // fixed input functions only apply on inputs not in general mode
  assign o_manual_ref_select = s_reg.oe_n[sgirc_pkg::PIN_REFSEL]
                               && !s_reg.cfg.gp_mode[sgirc_pkg::PIN_REFSEL]
                               && s_reg.general_input_bit[sgirc_pkg::PIN_REFSEL];
  assign o_oe_map_select = s_reg.general_input_bit[1:0] & s_reg.oe_n[1:0]
                           & ~(s_reg.cfg.gp_mode[1:0] & {2{s_reg.cfg_loaded}});
  assign o_clk_out_en    = (s_reg.st == sgirc_pkg::SGIRC_ST_RUN) ? map_rdata : sgirc_pkg::RST_OE;
  assign o_otp_load      = (s_reg.st == sgirc_pkg::SGIRC_ST_OTP);
  assign o_eep_load      = (s_reg.st == sgirc_pkg::SGIRC_ST_EEP);
  assign o_rest_load     = (s_reg.st == sgirc_pkg::SGIRC_ST_REST);
  assign o_serial_accept = running;
  assign o_pll_lock_try  = running;
  assign o_outputs_sync  = (s_reg.st == sgirc_pkg::SGIRC_ST_RUN);
  assign o_flags         = s_reg.flags;
  assign o_dev_irq       = s_reg.irq;
  assign o_irq_out_n     = !s_reg.irq;
  assign o_pll_unlocked_flag    = s_reg.unlocked;
  assign o_ref_signal_lost_flag = i_pll_sts.ref_failed;
  assign o_holdover_flag        = i_pll_sts.holdover;

  a_irq_pin_level: assert property (@(posedge i_mclk) disable iff (!rst_comb_n)
    o_irq_out_n == !(|(o_flags & s_reg.en)))
    else $error("irq pin disagrees with enabled flags");
  a_flag_sticks: assert property (@(posedge i_mclk) disable iff (!rst_comb_n)
    $rose(alarm[0]) |=> o_flags[0])
    else $error("unlock alarm did not set its flag");
  a_los_flag_set: assert property (@(posedge i_mclk) disable iff (!rst_comb_n)
    alarm[sgirc_pkg::FLG_LOS1] |=> o_flags[sgirc_pkg::FLG_LOS1])
    else $error("reference loss did not set its flag");
  a_flag_hold: assert property (@(posedge i_mclk) disable iff (!rst_comb_n)
    (o_flags[1] && i_pll_sts.holdover) |=> o_flags[1])
    else $error("flag cleared while alarm present");
  a_clear_honoured: assert property (@(posedge i_mclk) disable iff (!rst_comb_n)
    (!alarm[0] && i_flag_clr[0] && running) |=> !o_flags[0])
    else $error("write-one clear ignored after alarm gone");
  a_enables_held: assert property (@(posedge i_mclk) disable iff (!rst_comb_n)
    !running |-> (s_reg.en == sgirc_pkg::RST_ENABLES))
    else $error("interrupt enable set before serial access");
  a_irq_enable: assert property (@(posedge i_mclk) disable iff (!rst_comb_n)
    (o_flags == 4'h0) |-> !o_dev_irq)
    else $error("interrupt without a set flag");
  a_pins_input: assert property (@(posedge i_mclk) disable iff (!rst_comb_n)
    !s_reg.cfg_loaded |-> (o_gpio_oe_n == 4'hF))
    else $error("pin driven before configuration");
  a_fixed_unlock_pin: assert property (@(posedge i_mclk) disable iff (!rst_comb_n)
    (s_reg.cfg_loaded && !s_reg.cfg.gp_mode[sgirc_pkg::PIN_LOL])
    |-> (o_gpio[sgirc_pkg::PIN_LOL] == o_pll_unlocked_flag))
    else $error("unlock pin does not follow its status");
  a_ref_select_gate: assert property (@(posedge i_mclk) disable iff (!rst_comb_n)
    !s_reg.oe_n[sgirc_pkg::PIN_REFSEL] |-> !o_manual_ref_select)
    else $error("reference select taken from a driven pin");
  sequence s_boot_eep;
    (s_reg.st == sgirc_pkg::SGIRC_ST_EEP);
  endsequence
  a_no_serial_boot: assert property (@(posedge i_mclk) disable iff (!rst_comb_n)
    s_boot_eep |-> !o_serial_accept)
    else $error("serial answered during boot");
  sequence s_otp_to_eep;
    o_otp_load && i_otp_done && i_boot_eep;
  endsequence
  a_boot_eep_order: assert property (@(posedge i_mclk) disable iff (!rst_comb_n)
    s_otp_to_eep |=> (o_eep_load && !o_serial_accept))
    else $error("external load did not follow initial block");
  a_boot_rest_order: assert property (@(posedge i_mclk) disable iff (!rst_comb_n)
    (o_otp_load && i_otp_done && !i_boot_eep) |=> o_rest_load)
    else $error("internal load did not follow initial block");
  a_outputs_off: assert property (@(posedge i_mclk) disable iff (!rst_comb_n)
    (s_reg.st != sgirc_pkg::SGIRC_ST_RUN) |-> (o_clk_out_en == 4'h0))
    else $error("clock outputs enabled before run");
  a_unlock_mode: assert property (@(posedge i_mclk) disable iff (!rst_comb_n)
    (!i_pll_sts.pll_locked) |=> o_pll_unlocked_flag)
    else $error("unlock flag low while unlocked");
  sequence s_lock_no_sync;
    i_pll_sts.pll_locked && i_unlock_mode_sync && !i_pll_sts.sync_done;
  endsequence
  a_unlock_wait_sync: assert property (@(posedge i_mclk) disable iff (!rst_comb_n)
    s_lock_no_sync |=> o_pll_unlocked_flag)
    else $error("unlock flag dropped before sync done");
  a_unlock_on_lock: assert property (@(posedge i_mclk) disable iff (!rst_comb_n)
    (i_pll_sts.pll_locked && !i_unlock_mode_sync) |=> !o_pll_unlocked_flag)
    else $error("unlock flag held after lock");

endmodule : sgirc_top
`default_nettype wire

// ### dv/sgirc_board_model.sv
// board side of the four status pins: resolves each pin from both drivers
`timescale 1ns/1ps
`default_nettype none
module sgirc_board_model (
  input  wire logic       i_mclk,
  input  wire logic [3:0] i_dev_val,
  input  wire logic [3:0] i_dev_oe_n,
  input  wire logic [3:0] i_brd_val,
  input  wire logic [3:0] i_brd_en,
  output logic      [3:0] o_pin
);
  logic [3:0] last_reg;

  // undriven pin has no pull: show the inverse of the last level, never a stale copy
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (!i_dev_oe_n[i]) o_pin[i] = i_dev_val[i];
      else if (i_brd_en[i]) o_pin[i] = i_brd_val[i];
      else o_pin[i] = ~last_reg[i];
    end
  end

  always_ff @(posedge i_mclk) begin
    last_reg <= o_pin;
  end
endmodule : sgirc_board_model
`default_nettype wire

// ### dv/sgirc_top_tb.sv
// self-checking bench for the status pin, interrupt and start-up block
`timescale 1ns/1ps
`default_nettype none
module sgirc_top_tb;
  logic clk, rst_n, mrst_n, cfg_we, mode_sync, en_we, map_we;
  logic otp_done, boot_eep, boot_rest, eep_done, rest_done;
  logic [3:0] pin, dq, oe_n, clr, en, map_data, brd, brd_en, gin, ce, flags;
  logic [1:0] map_idx, msel, ref_signal_lost_flag;
  logic otp_ld, eep_ld, rest_ld, acc, lock_try, sync, rsel, dirq, irq_n, unl, hold;
  sgirc_pkg::sgirc_pin_cfg_s pcfg;
  sgirc_pkg::sgirc_pll_sts_s sts;
  int err_total, n_compared;

  sgirc_top #(.POR_CYCLES_P(4)) u_dut (.i_mclk(clk), .i_rst_n(rst_n),
    .i_master_reset_in_n(mrst_n), .i_gpio(pin), .o_gpio(dq), .o_gpio_oe_n(oe_n),
    .i_pin_cfg(pcfg), .i_cfg_we(cfg_we), .i_unlock_mode_sync(mode_sync), .i_pll_sts(sts),
    .i_flag_clr(clr), .i_irq_enable(en), .i_irq_enable_we(en_we), .i_oe_map_we(map_we),
    .i_oe_map_idx(map_idx), .i_oe_map_data(map_data), .i_otp_done(otp_done),
    .i_boot_eep(boot_eep), .i_boot_otp_rest(boot_rest), .i_eep_done(eep_done),
    .i_rest_done(rest_done), .o_otp_load(otp_ld), .o_eep_load(eep_ld), .o_rest_load(rest_ld),
    .o_serial_accept(acc), .o_pll_lock_try(lock_try), .o_outputs_sync(sync),
    .o_general_input_bit(gin), .o_manual_ref_select(rsel), .o_oe_map_select(msel),
    .o_clk_out_en(ce), .o_flags(flags), .o_dev_irq(dirq), .o_irq_out_n(irq_n),
    .o_pll_unlocked_flag(unl), .o_ref_signal_lost_flag(ref_signal_lost_flag), .o_holdover_flag(hold));

  sgirc_board_model u_board (.i_mclk(clk), .i_dev_val(dq), .i_dev_oe_n(oe_n),
    .i_brd_val(brd), .i_brd_en(brd_en), .o_pin(pin));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic wrap_up();
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // bounded wait on one of the sequencer outputs
  task automatic wait_hi(input int s);
    int n;
    logic v;
    n = 0;
    v = 1'b0;
    while (n < 60) begin
      case (s)
        0: v = otp_ld;
        1: v = eep_ld;
        2: v = rest_ld;
        3: v = acc;
        default: v = sync;
      endcase
      if (v === 1'b1) break;
      cyc(1);
      n++;
    end
    if (n >= 60) begin
      err_total++;
      $display("[ERR] %0t wait timeout on %0d", $time, s);
      wrap_up();
    end
  endtask : wait_hi

  task automatic cfg(input logic [3:0] d, input logic [3:0] m, input logic [3:0] o);
    pcfg = '{dir_out: d, gp_mode: m, gp_out: o};
    cfg_we = 1'b1;
    cyc(1);
    cfg_we = 1'b0;
    cyc(3);
  endtask : cfg

  task automatic alarm(input int i, input logic v);
    case (i)
      0: sts.pll_locked = ~v;
      1: sts.holdover = v;
      2: sts.ref_failed[0] = v;
      default: sts.ref_failed[1] = v;
    endcase
  endtask : alarm

  task automatic clear(input logic [3:0] b);
    clr = b;
    cyc(1);
    clr = 4'h0;
    cyc(2);
  endtask : clear

  initial begin
    err_total = 0;
    n_compared = 0;
    rst_n = 1'b0; mrst_n = 1'b1; cfg_we = 1'b0; mode_sync = 1'b0; en_we = 1'b0;
    map_we = 1'b0; otp_done = 1'b0; boot_eep = 1'b1; boot_rest = 1'b0; eep_done = 1'b0;
    rest_done = 1'b0; clr = 4'h0; en = 4'h0; map_data = 4'h0; map_idx = 2'h0;
    brd = 4'h6; brd_en = 4'hF; pcfg = '0; sts = '{1'b0, 1'b1, 1'b0, 2'h0};
    cyc(20);
    chk(8'(oe_n), 8'h0F);
    chk(8'({irq_n, flags}), 8'h10);
    chk(8'(ce), 8'h00);
    chk(8'(acc), 8'h00);
    rst_n = 1'b1;
    cyc(2);
    chk(8'(otp_ld), 8'h00);
    wait_hi(0);
    chk(8'({rsel, msel}), 8'h06);
    en = 4'hF;
    en_we = 1'b1;
    cyc(1);
    en_we = 1'b0;
    otp_done = 1'b1;
    wait_hi(1);
    chk(8'(acc), 8'h00);
    otp_done = 1'b0;
    eep_done = 1'b1;
    wait_hi(3);
    chk(8'({lock_try, sync}), 8'h02);
    eep_done = 1'b0;
    sts.pll_locked = 1'b1;
    wait_hi(4);
    clear(4'hF);
    // early enable write was refused, so a raised flag must not interrupt
    alarm(1, 1'b1);
    cyc(2);
    chk(8'({flags[1], dirq, irq_n}), 8'h05);
    for (int i = 0; i < 4; i++) begin
      map_we = 1'b1;
      map_idx = 2'(i);
      map_data = 4'h9 ^ 4'(i);
      cyc(1);
    end
    map_we = 1'b0;
    for (int i = 0; i < 4; i++) begin
      brd = 4'h4 | 4'(i);
      cyc(4);
      chk(8'({rsel, msel}), 8'(4 | i));
      chk(8'(ce), 8'(9 ^ i));
    end
    cfg(4'h0, 4'hF, 4'h0);
    brd = 4'h5;
    cyc(3);
    chk(8'({gin, oe_n}), 8'h5F);
    brd_en = 4'h0;
    cfg(4'hF, 4'hF, 4'hA);
    chk(8'({dq, oe_n}), 8'hA0);
    alarm(3, 1'b1);
    cfg(4'hF, 4'h0, 4'h0);
    chk(8'({dq, ref_signal_lost_flag, hold}), 8'h1D);
    alarm(0, 1'b1);
    cyc(3);
    chk(8'({dq[3], unl}), 8'h03);
    mode_sync = 1'b1;
    sts.sync_done = 1'b0;
    sts.pll_locked = 1'b1;
    cyc(3);
    chk(8'(unl), 8'h01);
    sts.sync_done = 1'b1;
    cyc(3);
    chk(8'(unl), 8'h00);
    mode_sync = 1'b0;
    sts = '{1'b1, 1'b1, 1'b0, 2'h0};
    cyc(2);
    clear(4'hF);
    for (int i = 0; i < 4; i++) begin
      en = 4'h1 << i;
      en_we = 1'b1;
      cyc(1);
      en_we = 1'b0;
      alarm(i, 1'b1);
      cyc(2);
      chk(8'({flags, dirq, irq_n}), 8'((1 << (i + 2)) | 2));
      clear(4'hF);
      chk(8'(flags), 8'(1 << i));
      alarm(i, 1'b0);
      cyc(2);
      chk(8'(flags), 8'(1 << i));
      clear(4'h1 << i);
      chk(8'({flags, dirq, irq_n}), 8'h01);
    end
    alarm(2, 1'b1);
    cyc(3);
    mrst_n = 1'b0;
    cyc(2);
    chk(8'({irq_n, flags, acc}), 8'h20);
    chk(8'({oe_n, ce}), 8'hF0);
    boot_eep = 1'b0;
    boot_rest = 1'b1;
    mrst_n = 1'b1;
    cyc(2);
    chk(8'(otp_ld), 8'h00);
    wait_hi(0);
    otp_done = 1'b1;
    wait_hi(2);
    chk(8'({eep_ld, acc}), 8'h00);
    otp_done = 1'b0;
    rest_done = 1'b1;
    wait_hi(3);
    chk(8'(lock_try), 8'h01);
    wrap_up();
  end
endmodule : sgirc_top_tb
`default_nettype wire
